// ### dv/gsi_host.sv
`timescale 1ns/1ps
`default_nettype none
// i2c controller model; 1 releases a line and the pull-up makes it high
module gsi_host (
    input  wire logic mclk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda
);
    initial scl = 1'b1;
    initial sda = 1'b1;
    // quarter of a bit: eight core cycles
    task automatic q();
        repeat (8) @(posedge mclk);
    endtask : q
    // start or repeated start: sda falls while scl high
    task automatic go();
        sda <= 1'b1; q(); scl <= 1'b1; q(); sda <= 1'b0; q(); scl <= 1'b0; q();
    endtask : go
    // one bit, wire level read back in the middle of scl high
    task automatic bt(input logic b, output logic v);
        sda <= b; q(); scl <= 1'b1; q(); v = sda_w; q(); scl <= 1'b0; q();
    endtask : bt
    // byte msb first, then acknowledge bit ab; a is the wire level there
    task automatic xb(input logic [7:0] d, input logic ab, output logic [7:0] r,
                      output logic a);
        for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
        bt(ab, a);
    endtask : xb
    // stop: sda rises while scl high
    task automatic stop();
        sda <= 1'b0; q(); scl <= 1'b1; q(); sda <= 1'b1; q(); q();
    endtask : stop
    // hold both lines low until the next stop
    task automatic low();
        sda <= 1'b0; q(); scl <= 1'b0;
    endtask : low
endmodule : gsi_host
`default_nettype wire

// ### dv/gsi_target_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gsi_target_tb;
    import gsi_pkg::*;
    logic mclk = 0, link_clk = 0, rst = 1, pwr_en = 1, fw_req_valid = 0, a, seen;
    gsi_pwr_t fw_req_mode = PWR_FULL, pwr_state;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, core_pwr_en, hf_osc_en, lf_osc_en;
    logic meas_pulse, bus_timeout, h_scl, h_sda, scl_w, sda_w;
    logic [7:0] r;
    logic [2:0] k;
    int num_errors = 0, check_count = 0;
    // wired-and of host and device drivers
    assign scl_w = h_scl & (scl_oe_n | scl_out);
    assign sda_w = h_sda & (sda_oe_n | sda_out);
    // {addr, cmd, data, expected nack bits of addr/cmd/data}
    logic [26:0] tbl [6] = '{{8'hAA, 8'h02, 8'h5A, 3'b000}, {8'hAA, 8'h03, 8'hC3, 3'b000},
        {8'hAA, 8'h01, 8'h11, 3'b001}, {8'hAA, 8'h40, 8'h11, 3'b001},
        {8'hAA, 8'h80, 8'h11, 3'b011}, {8'hA8, 8'h02, 8'hFF, 3'b111}};
    initial forever #12.5 mclk = ~mclk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    gsi_host h (.mclk(mclk), .sda_w(sda_w), .scl(h_scl), .sda(h_sda));
    gsi_target #(.TOUT_CYC(200), .MEAS_CYC(50)) dut (.mclk(mclk), .rst(rst),
        .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pwr_en(pwr_en),
        .fw_req_valid(fw_req_valid), .fw_req_mode(fw_req_mode), .pwr_state(pwr_state),
        .core_pwr_en(core_pwr_en), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
        .meas_pulse(meas_pulse), .bus_timeout(bus_timeout));
    // compare one byte-wide result
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // single write, acknowledge pattern compared
    task automatic wr(input logic [26:0] t);
        h.go(); h.xb(t[26:19], 1, r, k[2]); h.xb(t[18:11], 1, r, k[1]);
        h.xb(t[10:3], 1, r, k[0]); h.stop(); chk({5'h0, k}, {5'h0, t[2:0]});
    endtask : wr
    // read two bytes from location c
    task automatic rd(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
        h.go(); h.xb(8'hAA, 1, r, a); h.xb(c, 1, r, a); h.go(); h.xb(8'hAB, 1, r, a);
        h.xb(8'hFF, 0, r, a); chk(r, e0); h.xb(8'hFF, 1, r, a); chk(r, e1); h.stop();
    endtask : rd
    // power outputs {state, core, hf, lf} and whether a measurement ran
    task automatic pm(input logic [7:0] e, input logic m);
        seen = 0;
        repeat (80) @(posedge mclk) seen |= meas_pulse;
        chk({3'h0, pwr_state, core_pwr_en, hf_osc_en, lf_osc_en}, e); chk({7'h0, seen}, {7'h0, m});
    endtask : pm
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge mclk);
        chk({6'h0, pwr_state}, 8'h03);
        rst <= 0;
        pm(8'h07, 0);
        foreach (tbl[i]) wr(tbl[i]);
        rd(8'h02, 8'h5A, 8'hC3);
        h.go(); h.xb(8'hAA, 1, r, a); h.xb(8'h04, 1, r, a); h.xb(8'h77, 1, r, k[2]);
        h.xb(8'h88, 1, r, k[1]); h.xb(8'h99, 1, r, k[0]); h.stop();
        chk({5'h0, k}, 8'h03);
        rd(8'h04, 8'h77, 8'h00);
        wr({8'hAA, 8'h00, 8'h02, 3'b000}); pm(8'h15, 1);
        wr({8'hAA, 8'h00, 8'h01, 3'b000}); pm(8'h0F, 1);
        rd(8'h7F, 8'h00, 8'h01);
        wr({8'hAA, 8'h00, 8'h00, 3'b000}); pm(8'h07, 0);
        // stall a read while the device pulls sda low for bit 7 of 0x5A
        h.go(); h.xb(8'hAA, 1, r, a); h.xb(8'h02, 1, r, a); h.go(); h.xb(8'hAB, 1, r, a);
        h.low(); repeat (150) @(posedge mclk);
        chk({6'h0, bus_timeout, sda_oe_n}, 8'h00);
        repeat (100) @(posedge mclk);
        chk({6'h0, bus_timeout, sda_oe_n}, 8'h03); h.stop();
        pwr_en <= 0; pm(8'h18, 0); wr({8'hAA, 8'h02, 8'h11, 3'b111});
        chk({6'h0, pwr_state}, 8'h03);
        pwr_en <= 1; pm(8'h07, 0);
        // firmware request path: sleep taken, power-off ignored
        fw_req_mode <= PWR_SLEEP;
        fw_req_valid <= 1;
        @(posedge mclk) fw_req_valid <= 0;
        pm(8'h15, 1);
        fw_req_mode <= PWR_OFF;
        fw_req_valid <= 1;
        @(posedge mclk) fw_req_valid <= 0;
        pm(8'h15, 1);
        report_and_stop();
    end
endmodule : gsi_target_tb
`default_nettype wire

// ### rtl/gsi_pkg.sv
// Functional notes
// - write: ack command and one data byte only
// - incremental read past 0x7F wraps to 0x00
// - release SDA and SCL after bus-low timeout
// - exactly four power states
// - full power: everything on, bus serviced
// - doze: periodic measurement, stays in doze
// - sleep: low osc on, high osc off
// - power-off left only via power-enable pin
// - answer only target address 1010101
// - pointer advances on every acknowledged data byte
// - nack command byte above 0x7F
// - nack data written to read-only location
package gsi_pkg;

    // ----------------------------------------------------------------
    // bus addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] TGT_ADDR   = 7'h55; // 7-bit target address
    localparam logic [6:0] CMD_CTRL   = 7'h00; // host power-mode control byte
    localparam logic [6:0] CMD_STATUS = 7'h01; // read-only status byte
    localparam logic [6:0] RW_LIMIT   = 7'h40; // locations below are writable, except the status byte
    localparam logic [7:0] MEM_RESET  = 8'h00; // command memory after reset

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0; // mode request in control byte
    localparam int STAT_MODE_LSB = 0; // power state in status byte
    localparam int STAT_CNT_LSB  = 2; // update counter in status byte

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MCLK_KHZ  = 40000;                     // core clock rate
    localparam int TOUT_US   = 2000;                      // bus-low timeout
    localparam int TOUT_CYC  = TOUT_US * MCLK_KHZ / 1000; // timeout in cycles
    localparam int MEAS_US   = 1000;                      // measurement period
    localparam int MEAS_CYC  = MEAS_US * MCLK_KHZ / 1000; // period in cycles

    // power states
    typedef enum logic [1:0] {
        PWR_FULL  = 2'h0,
        PWR_DOZE  = 2'h1,
        PWR_SLEEP = 2'h2,
        PWR_OFF   = 2'h3
    } gsi_pwr_t;

    // bus engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h2,
        ST_CMD  = 4'h3,
        ST_CACK = 4'h4,
        ST_WDAT = 4'h5,
        ST_WACK = 4'h6,
        ST_RDAT = 4'h7,
        ST_RACK = 4'h8,
        ST_WAIT = 4'h9
    } gsi_st_t;

endpackage : gsi_pkg

// ### rtl/gsi_target.sv
`timescale 1ns/1ps
`default_nettype none
module gsi_target #(
    parameter int TOUT_CYC = gsi_pkg::TOUT_CYC, // bus-low timeout, mclk cycles
    parameter int MEAS_CYC = gsi_pkg::MEAS_CYC  // doze/sleep measurement period
) (
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           link_clk,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                scl_out,
    output logic                scl_oe_n,
    output logic                sda_out,
    output logic                sda_oe_n,
    input  wire logic           pwr_en,
    input  wire logic           fw_req_valid,
    input  wire gsi_pkg::gsi_pwr_t fw_req_mode,
    output gsi_pkg::gsi_pwr_t   pwr_state,
    output logic                core_pwr_en,
    output logic                hf_osc_en,
    output logic                lf_osc_en,
    output logic                meas_pulse,
    output logic                bus_timeout
);
    import gsi_pkg::*;

    localparam int TW = $clog2(TOUT_CYC + 1); // timeout counter width
    localparam int MW = $clog2(MEAS_CYC);     // period counter width

    // ----------------------------------------------------------------
    // state records
    // ----------------------------------------------------------------
    typedef struct packed {
        logic          scl_m, sda_m, ce_m; // pin sync, first stage
        logic          scl_s, sda_s, ce_s; // pin sync, second stage
        logic [TW-1:0] tcnt;               // continuous low time
        logic          rel;                // timeout release level
        gsi_pwr_t      pst;                // power state
        logic [MW-1:0] mcnt;               // measurement timer
        logic          meas;               // measurement pulse
        logic          core, hf, lf;       // power and oscillator enables
        logic [5:0]    upd;                // data-set update count
        logic [7:0]    sent;               // last status byte sent
    } gsi_mc_t;

    typedef struct packed {
        logic          scl_m, sda_m, en_m, rel_m; // sync, first stage
        logic          scl_s, sda_s, en_s, rel_s; // sync, second stage
        logic          scl_d, sda_d;              // previous line levels
        gsi_st_t       st;                        // engine state
        logic [3:0]    cnt;                       // bit counter
        logic [7:0]    shft;                      // shift register
        logic [6:0]    ptr;                       // address pointer
        logic          first;                     // next byte is first data
        logic          rw;                        // direction bit
        logic          oe_n;                      // sda drive, low pulls
        logic          ctl_v;                     // control byte pulse
        logic [7:0]    ctl_d;                     // control byte
    } gsi_lk_t;

    gsi_mc_t    mc_reg, mc_next;
    gsi_lk_t    lk_reg, lk_next;
    logic [7:0] mem [128];          // command locations
    logic       mem_we;             // host write strobe
    logic [7:0] stat_byte;          // status byte to publish
    logic       stat_go, stat_rdy;  // status send handshake
    logic       stat_v;             // status arrived in link domain
    logic [7:0] stat_d;
    logic       host_v;             // control byte arrived in mclk domain
    logic [7:0] host_d;
    logic       rise, fall, start, stop;

    // host may write below the limit except the status byte
    function automatic logic writable(input logic [6:0] a);
        return (a < RW_LIMIT) && (a != CMD_STATUS);
    endfunction : writable

    // ----------------------------------------------------------------
    // domain crossings
    // ----------------------------------------------------------------
    gsi_word_xfer #(.W(8)) u_ctl (
        .src_clk   (link_clk),
        .dst_clk   (mclk),
        .rst       (rst),
        .src_valid (lk_reg.ctl_v),
        .src_data  (lk_reg.ctl_d),
        .src_ready (),
        .dst_valid (host_v),
        .dst_data  (host_d)
    );

    gsi_word_xfer #(.W(8)) u_stat (
        .src_clk   (mclk),
        .dst_clk   (link_clk),
        .rst       (rst),
        .src_valid (stat_go),
        .src_data  (stat_byte),
        .src_ready (stat_rdy),
        .dst_valid (stat_v),
        .dst_data  (stat_d)
    );

    assign stat_byte = {mc_reg.upd, mc_reg.pst};
    assign stat_go   = stat_rdy && (stat_byte != mc_reg.sent);

    // ----------------------------------------------------------------
    // core domain: timeout and power modes
    // ----------------------------------------------------------------
    always_comb begin
        gsi_pwr_t req;
        req           = gsi_pwr_t'(host_d[CTRL_MODE_LSB +: 2]);
        mc_next       = mc_reg;
        mc_next.scl_m = scl_in;
        mc_next.sda_m = sda_in;
        mc_next.ce_m  = pwr_en;
        mc_next.scl_s = mc_reg.scl_m;
        mc_next.sda_s = mc_reg.sda_m;
        mc_next.ce_s  = mc_reg.ce_m;
        mc_next.meas  = 1'b0;
        if (stat_go) mc_next.sent = stat_byte;
        // any high line restarts the low-time count
        if (mc_reg.scl_s || mc_reg.sda_s) mc_next.tcnt = '0;
        else if (mc_reg.tcnt != TW'(TOUT_CYC)) mc_next.tcnt = mc_reg.tcnt + 1'b1;
        mc_next.rel = mc_next.tcnt == TW'(TOUT_CYC);
        // power state: the pin overrides everything
        if (!mc_reg.ce_s) begin
            mc_next.pst = PWR_OFF;
        end else if (mc_reg.pst == PWR_OFF) begin
            mc_next.pst = PWR_FULL;
        end else if (host_v && req != PWR_OFF) begin
            mc_next.pst = req;
        end else if (fw_req_valid && fw_req_mode != PWR_OFF) begin
            mc_next.pst = fw_req_mode;
        end
        // periodic measurement in doze and sleep, state unchanged
        if (mc_reg.pst == PWR_DOZE || mc_reg.pst == PWR_SLEEP) begin
            if (mc_reg.mcnt == MW'(MEAS_CYC - 1)) begin
                mc_next.mcnt = '0;
                mc_next.meas = 1'b1;
                mc_next.upd  = mc_reg.upd + 1'b1;
            end else begin
                mc_next.mcnt = mc_reg.mcnt + 1'b1;
            end
        end else begin
            mc_next.mcnt = '0;
        end
        // enables follow the next state
        mc_next.core = mc_next.pst != PWR_OFF;
        mc_next.lf   = mc_next.pst != PWR_OFF;
        mc_next.hf   = mc_next.pst == PWR_FULL || mc_next.pst == PWR_DOZE;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) mc_reg <= '{pst: PWR_OFF, default: '0};
        else     mc_reg <= mc_next;
    end

    // ----------------------------------------------------------------
    // link domain: bus target engine
    // ----------------------------------------------------------------
    assign rise  = lk_reg.scl_s && !lk_reg.scl_d;
    assign fall  = !lk_reg.scl_s && lk_reg.scl_d;
    assign start = lk_reg.scl_s && lk_reg.scl_d && lk_reg.sda_d && !lk_reg.sda_s;
    assign stop  = lk_reg.scl_s && lk_reg.scl_d && !lk_reg.sda_d && lk_reg.sda_s;

    always_comb begin
        logic [6:0] nxt;
        nxt           = 7'(lk_reg.ptr + 7'h01); // wraps 0x7F to 0x00
        lk_next       = lk_reg;
        lk_next.scl_m = scl_in;
        lk_next.sda_m = sda_in;
        lk_next.en_m  = mc_reg.core;
        lk_next.rel_m = mc_reg.rel;
        lk_next.scl_s = lk_reg.scl_m;
        lk_next.sda_s = lk_reg.sda_m;
        lk_next.en_s  = lk_reg.en_m;
        lk_next.rel_s = lk_reg.rel_m;
        lk_next.scl_d = lk_reg.scl_s;
        lk_next.sda_d = lk_reg.sda_s;
        lk_next.ctl_v = 1'b0;
        mem_we        = 1'b0;
        if (lk_reg.rel_s || !lk_reg.en_s) begin
            // timeout or power-off: let go of the bus
            lk_next.st   = ST_IDLE;
            lk_next.oe_n = 1'b1;
        end else if (start) begin
            lk_next.st   = ST_ADDR;
            lk_next.cnt  = '0;
            lk_next.oe_n = 1'b1;
        end else if (stop) begin
            lk_next.st   = ST_IDLE;
            lk_next.oe_n = 1'b1;
        end else begin
            unique case (lk_reg.st)
                ST_IDLE, ST_WAIT: begin
                    lk_next.oe_n = 1'b1;
                end
                ST_ADDR, ST_CMD, ST_WDAT: begin
                    if (rise) begin
                        lk_next.shft = {lk_reg.shft[6:0], lk_reg.sda_s};
                        lk_next.cnt  = lk_reg.cnt + 4'h1;
                    end else if (fall && lk_reg.cnt == 4'h8) begin
                        lk_next.cnt = '0;
                        if (lk_reg.st == ST_ADDR) begin
                            if (lk_reg.shft[7:1] == TGT_ADDR) begin
                                lk_next.st   = ST_AACK;
                                lk_next.oe_n = 1'b0;
                                lk_next.rw   = lk_reg.shft[0];
                            end else begin
                                lk_next.st = ST_WAIT;
                            end
                        end else if (lk_reg.st == ST_CMD) begin
                            lk_next.st    = ST_CACK;
                            lk_next.oe_n  = lk_reg.shft[7];
                            lk_next.first = 1'b1;
                            if (!lk_reg.shft[7]) lk_next.ptr = lk_reg.shft[6:0];
                        end else begin
                            lk_next.st    = ST_WACK;
                            lk_next.first = 1'b0;
                            // only the first byte to a writable place is taken
                            if (lk_reg.first && writable(lk_reg.ptr)) begin
                                lk_next.oe_n = 1'b0;
                                mem_we       = 1'b1;
                                lk_next.ptr  = nxt;
                                if (lk_reg.ptr == CMD_CTRL) begin
                                    lk_next.ctl_v = 1'b1;
                                    lk_next.ctl_d = lk_reg.shft;
                                end
                            end else begin
                                lk_next.oe_n = 1'b1;
                            end
                        end
                    end
                end
                ST_AACK: begin
                    if (fall) begin
                        if (lk_reg.rw) begin
                            // quick read starts at the current pointer
                            lk_next.st   = ST_RDAT;
                            lk_next.oe_n = mem[lk_reg.ptr][7];
                            lk_next.shft = {mem[lk_reg.ptr][6:0], 1'b0};
                            lk_next.cnt  = 4'h1;
                        end else begin
                            lk_next.st   = ST_CMD;
                            lk_next.oe_n = 1'b1;
                        end
                    end
                end
                ST_CACK: begin
                    if (fall) begin
                        lk_next.st   = lk_reg.oe_n ? ST_WAIT : ST_WDAT;
                        lk_next.oe_n = 1'b1;
                    end
                end
                ST_WACK: begin
                    if (fall) begin
                        lk_next.st   = ST_WDAT;
                        lk_next.oe_n = 1'b1;
                    end
                end
                ST_RDAT: begin
                    if (fall) begin
                        if (lk_reg.cnt == 4'h8) begin
                            lk_next.st   = ST_RACK;
                            lk_next.oe_n = 1'b1;
                        end else begin
                            lk_next.oe_n = lk_reg.shft[7];
                            lk_next.shft = {lk_reg.shft[6:0], 1'b0};
                            lk_next.cnt  = lk_reg.cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (rise) begin
                        if (!lk_reg.sda_s) begin
                            // controller acked: advance and fetch next byte
                            lk_next.ptr  = nxt;
                            lk_next.shft = mem[nxt];
                            lk_next.cnt  = '0;
                            lk_next.st   = ST_RDAT;
                        end else begin
                            lk_next.st = ST_WAIT;
                        end
                    end
                end
                default: begin
                    lk_next.st   = ST_IDLE;
                    lk_next.oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) lk_reg <= '{st: ST_IDLE, oe_n: 1'b1, default: '0};
        else     lk_reg <= lk_next;
    end

    // command memory: host writes and status updates
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 128; i++) mem[i] <= MEM_RESET;
        end else begin
            if (mem_we) mem[lk_reg.ptr] <= lk_reg.shft;
            if (stat_v) mem[CMD_STATUS] <= stat_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs from flip-flops, with scl_out, sda_out and scl_oe_n tied constant
    // ----------------------------------------------------------------
    assign scl_out     = 1'b0;
    assign sda_out     = 1'b0;
    assign scl_oe_n    = 1'b1; // clock is never stretched
    assign sda_oe_n    = lk_reg.oe_n;
    assign pwr_state   = mc_reg.pst;
    assign core_pwr_en = mc_reg.core;
    assign hf_osc_en   = mc_reg.hf;
    assign lf_osc_en   = mc_reg.lf;
    assign meas_pulse  = mc_reg.meas;
    assign bus_timeout = mc_reg.rel;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_lines_low_at_limit;
        !mc_reg.scl_s && !mc_reg.sda_s && mc_reg.tcnt == TW'(TOUT_CYC - 1);
    endsequence

    // release is checked per domain: the level here, the pin side on link_clk
    a_tout_release: assert property (@(posedge mclk) disable iff (rst)
        s_lines_low_at_limit |=> mc_reg.rel)
        else $error("timeout level not raised");
    a_tout_letgo: assert property (@(posedge link_clk) disable iff (rst)
        lk_reg.rel_s |=> (lk_reg.oe_n && lk_reg.st == ST_IDLE))
        else $error("timeout did not release the bus");
    a_tout_restart: assert property (@(posedge mclk) disable iff (rst)
        (mc_reg.scl_s || mc_reg.sda_s) |=> (mc_reg.tcnt == '0 && !mc_reg.rel))
        else $error("timeout count not restarted by a high line");
    a_off_pin_only: assert property (@(posedge mclk) disable iff (rst)
        (mc_reg.pst == PWR_OFF && !mc_reg.ce_s) |=> mc_reg.pst == PWR_OFF)
        else $error("left power-off without the pin");
    a_full_all_on: assert property (@(posedge mclk) disable iff (rst)
        mc_reg.pst == PWR_FULL |-> (mc_reg.core && mc_reg.hf && mc_reg.lf))
        else $error("full power with a domain off");
    a_sleep_osc: assert property (@(posedge mclk) disable iff (rst)
        mc_reg.pst == PWR_SLEEP |-> (!mc_reg.hf && mc_reg.lf))
        else $error("wrong oscillators in sleep");
    a_doze_return: assert property (@(posedge mclk) disable iff (rst)
        (mc_reg.pst == PWR_DOZE && mc_reg.mcnt == MW'(MEAS_CYC - 1) && mc_reg.ce_s
         && !host_v && !fw_req_valid) |=> (mc_reg.meas && mc_reg.pst == PWR_DOZE))
        else $error("doze measurement missing or state left");
    a_addr_match: assert property (@(posedge link_clk) disable iff (rst)
        $rose(lk_reg.st == ST_AACK) |-> $past(lk_reg.shft[7:1]) == TGT_ADDR)
        else $error("acked a foreign address");
    a_cmd_nack: assert property (@(posedge link_clk) disable iff (rst)
        (lk_reg.st == ST_CMD && fall && lk_reg.cnt == 4'h8 && lk_reg.shft[7]
         && !lk_reg.rel_s && lk_reg.en_s) |=> (lk_reg.st == ST_CACK && lk_reg.oe_n))
        else $error("command above 0x7F acked");
    a_extra_nack: assert property (@(posedge link_clk) disable iff (rst)
        (lk_reg.st == ST_WDAT && fall && lk_reg.cnt == 4'h8 && !lk_reg.first
         && !lk_reg.rel_s && lk_reg.en_s) |=> (lk_reg.st == ST_WACK && lk_reg.oe_n))
        else $error("extra write byte acked");
    a_ro_nack: assert property (@(posedge link_clk) disable iff (rst)
        (lk_reg.st == ST_WDAT && fall && lk_reg.cnt == 4'h8 && lk_reg.ptr == CMD_STATUS
         && !lk_reg.rel_s && lk_reg.en_s && !start && !stop) |=> lk_reg.oe_n)
        else $error("read-only location acked");
    a_ptr_wrap: assert property (@(posedge link_clk) disable iff (rst)
        (lk_reg.st == ST_RACK && rise && !lk_reg.sda_s && lk_reg.ptr == 7'h7F
         && !lk_reg.rel_s && lk_reg.en_s && !start && !stop) |=> lk_reg.ptr == 7'h00)
        else $error("read pointer did not wrap");
endmodule : gsi_target
`default_nettype wire

// ### rtl/gsi_word_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module gsi_word_xfer #(
    parameter int W = 8
) (
    input  wire logic         src_clk,
    input  wire logic         dst_clk,
    input  wire logic         rst,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_ready,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);
    // ----------------------------------------------------------------
    // state of each domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic         req;   // toggles once per word
        logic         ack_m; // ack sync, first stage
        logic         ack_s; // ack sync, second stage
        logic [W-1:0] data;  // held until ack returns
    } gsi_xs_t;

    typedef struct packed {
        logic         req_m; // req sync, first stage
        logic         req_s; // req sync, second stage
        logic         req_d; // last seen req, doubles as ack
        logic         vld;   // one-cycle arrival pulse
        logic [W-1:0] data;  // captured word
    } gsi_xd_t;

    gsi_xs_t s_reg, s_next;
    gsi_xd_t d_reg, d_next;

    // source side: accept a word only when the previous one is acked
    always_comb begin
        s_next       = s_reg;
        s_next.ack_m = d_reg.req_d;
        s_next.ack_s = s_reg.ack_m;
        if (src_valid && (s_reg.req == s_reg.ack_s)) begin
            s_next.req  = ~s_reg.req;
            s_next.data = src_data;
        end
    end

    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) s_reg <= '0;
        else     s_reg <= s_next;
    end

    // destination side: word is stable while req differs from ack
    always_comb begin
        d_next       = d_reg;
        d_next.req_m = s_reg.req;
        d_next.req_s = d_reg.req_m;
        d_next.req_d = d_reg.req_s;
        d_next.vld   = d_reg.req_s != d_reg.req_d;
        if (d_reg.req_s != d_reg.req_d) d_next.data = s_reg.data;
    end

    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) d_reg <= '0;
        else     d_reg <= d_next;
    end

    assign src_ready = s_reg.req == s_reg.ack_s;
    assign dst_valid = d_reg.vld;
    assign dst_data  = d_reg.data;
endmodule : gsi_word_xfer
`default_nettype wire
